// ---- lbm_pkg.sv ----
// shared constants and types of the led boost mode control
package lbm_pkg;
  // register offsets
  localparam logic [7:0] CTRL1_ADDR  = 8'h00;
  localparam logic [7:0] CTRL2_ADDR  = 8'h01;
  localparam logic [7:0] MODE_ADDR   = 8'h02;
  localparam logic [7:0] ASSIGN_ADDR = 8'h03;
  localparam logic [7:0] STATUS_ADDR = 8'h20;
  // field positions
  localparam int RAIL_EN_BIT = 0;
  localparam int PRIO_BIT    = 1;
  localparam int LEVEL_LSB   = 6;
  localparam int STROBE_INPUT_ONE_EN_BIT = 4;
  localparam int STROBE_INPUT_TWO_EN_BIT = 5;
  // reset values
  localparam logic [7:0] CTRL1_RST  = 8'h80;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] ASSIGN_RST = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS     = 50;
  localparam int RAMP_STEP_NS      = 1000;
  localparam int RAMP_STEP_CYC     = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_TIMEOUT_US  = 600;
  localparam int FLASH_TIMEOUT_CYC = (FLASH_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  // per-output mode codes
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_IR    = 2'b01,
    MODE_TORCH = 2'b10,
    MODE_FLASH = 2'b11
  } lbm_mode_e;
  // strobe assignment codes
  localparam logic [1:0] ASN_ONE = 2'b01;
  localparam logic [1:0] ASN_TWO = 2'b10;
  // output voltage selection
  typedef enum logic [2:0] {
    VOUT_OFF    = 3'b000,
    VOUT_PRECHG = 3'b001,
    VOUT_TRACK  = 3'b010,
    VOUT_RAIL   = 3'b011,
    VOUT_PASS   = 3'b100
  } lbm_vout_e;
  // converter sequence
  typedef enum logic [1:0] {
    ST_STANDBY   = 2'b00,
    ST_PRECHARGE = 2'b01,
    ST_PASS      = 2'b10,
    ST_BOOST     = 2'b11
  } lbm_state_e;
  // ramp generator state
  typedef struct packed {
    logic [15:0]     tick;
    logic [3:0][7:0] level;
  } lbm_ramp_s;
  // top state
  typedef struct packed {
    lbm_state_e  st;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  mode;
    logic [7:0]  asn;
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic [15:0] cnt;
    logic        mode_chg;
    logic [7:0]  rdata;
    logic [3:0]  src_on;
    logic        boost;
    logic        prechg;
    lbm_vout_e   vsel;
  } lbm_top_s;
endpackage

// ---- lbm_ramp_if.sv ----
// link between mode control and current ramp generator
`timescale 1ns/1ns
`default_nettype none
interface lbm_ramp_if;
  logic [3:0]      run;
  logic [3:0]      jump;
  logic [3:0][7:0] target;
  logic [3:0][7:0] level;
  modport ctl (output run, jump, target, input level);
  modport gen (input run, jump, target, output level);
endinterface
`default_nettype wire

// ---- lbm_ramp.sv ----
// per-output current ramp, one step per ramp tick
`timescale 1ns/1ns
`default_nettype none
module lbm_ramp #(
  parameter int unsigned STEP_CYC = lbm_pkg::RAMP_STEP_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // ramp link
  lbm_ramp_if.gen   rif
);
  lbm_pkg::lbm_ramp_s r;
  lbm_pkg::lbm_ramp_s next_r;
  logic               tick;

  // step divider and level walk
  always_comb begin
    next_r = r;
    tick = (r.tick == 16'(STEP_CYC - 1));
    next_r.tick = tick ? 16'h0000 : r.tick + 16'h0001;
    for (int i = 0; i < 4; i++) begin
      if (!rif.run[i]) begin
        next_r.level[i] = 8'h00;
      end else if (rif.jump[i]) begin
        next_r.level[i] = rif.target[i];
      end else if (tick && r.level[i] < rif.target[i]) begin
        next_r.level[i] = r.level[i] + 8'h01;
      end else if (r.level[i] > rif.target[i]) begin
        next_r.level[i] = rif.target[i];
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rif.level = r.level;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ramp climbs by exactly one step per tick
  a_ramp_one_step: assert property (rif.run[0] && !rif.jump[0] && tick && r.level[0] < rif.target[0] && rif.run[0]
    |=> r.level[0] == $past(r.level[0]) + 8'h01 || !$past(rif.run[0]))
    else $error("ramp did not take one step");
endmodule
`default_nettype wire

// ---- lbm_ctrl.sv ----
// mode control of the quad led boost driver
// Behaviour
// - fixed-rail enable bit 0 of control 1 runs the boost as a rail.
// - bits 7:6 of control 1 pick 4.0, 4.5, 5.0 or 5.2 V.
// - priority bit 1: 0 keeps rail, 1 lets boost track the leds.
// - in led priority the output returns to rail level after driving.
// - direct mode changes allowed; standby resets the flash timer, ramp levels and sequences.
// - precharge output, sources off, until output reaches about 2.2 V or the input.
// - sources ramp through every current step, except ir outputs, which jump to their code.
// - start in pass, switch to boost when headroom is short.
// - rail off: disabled, precharge for ir, or track highest led.
// - rail on: regulate rail unless priority set and leds drive.
// - rail regulates only while target exceeds input, else pass.
// - per-output gate bits 3:0 of control 2 gate each output.
// - register flash timeout clears gate bits, unless mode changed.
// - strobe operation keeps gate bits; a fault or a register flash timeout on another output clears them.
// - bits 7:0 of strobe register assign outputs to either strobe.
// - per-output action follows strobe enable, pin level and mode.
`timescale 1ns/1ns
`default_nettype none
module lbm_ctrl #(
  parameter int unsigned FLASH_TO_CYC = lbm_pkg::FLASH_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // strobe pins
  input  wire logic             strobe_input_one,
  input  wire logic             strobe_input_two,
  // analog comparators and fault
  input  wire logic             vout_below_vin,
  input  wire logic             vout_precharged,
  input  wire logic             headroom_low,
  input  wire logic             rail_above_vin,
  input  wire logic             fault_event,
  // current targets
  input  wire logic [3:0][7:0]  flash_code,
  input  wire logic [3:0][7:0]  torch_code,
  // converter and source control
  output logic                  boost_switching,
  output logic                  precharge_on,
  output logic      [3:0]       source_on,
  output logic      [3:0][7:0]  led_code,
  output lbm_pkg::lbm_vout_e    vout_select,
  output logic      [1:0]       rail_level
);
  lbm_pkg::lbm_top_s r;
  lbm_pkg::lbm_top_s next_r;
  lbm_ramp_if        rif ();

  logic       s_strobe_input_one;
  logic       s_strobe_input_two;
  logic       s_below;
  logic       s_pre;
  logic       s_hr_low;
  logic       s_rail_hi;
  logic       s_fault;
  logic [3:0] gate;
  logic [1:0] str_en;
  logic       rail_en;
  logic       prio;
  logic [3:0] want;
  logic [3:0] ir_en;
  logic [3:0] reg_flash;
  logic [3:0] str_flash;
  logic       led_req;
  logic       ir_any;
  logic       active;
  logic       flash_live;
  logic       timeout;
  logic       need_boost;

  // synchronised comparator and pin levels
  assign s_strobe_input_one    = r.sync2[0];
  assign s_strobe_input_two    = r.sync2[1];
  assign s_below   = r.sync2[2];
  assign s_pre     = r.sync2[3];
  assign s_hr_low  = r.sync2[4];
  assign s_rail_hi = r.sync2[5];
  assign s_fault   = r.sync2[6];

  // control fields
  assign gate    = r.ctrl2[3:0];
  assign str_en  = {r.ctrl2[lbm_pkg::STROBE_INPUT_TWO_EN_BIT], r.ctrl2[lbm_pkg::STROBE_INPUT_ONE_EN_BIT]};
  assign rail_en = r.ctrl1[lbm_pkg::RAIL_EN_BIT];
  assign prio    = r.ctrl1[lbm_pkg::PRIO_BIT];

  // per-output action decode
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      logic [1:0] md;
      logic [1:0] asn;
      logic       sel_en;
      logic       pin;
      assign md     = r.mode[2*gi+1:2*gi];
      assign asn    = r.asn[2*gi+1:2*gi];
      assign sel_en = (asn == lbm_pkg::ASN_ONE && str_en[0]) || (asn == lbm_pkg::ASN_TWO && str_en[1]);
      assign pin    = (asn == lbm_pkg::ASN_ONE) ? s_strobe_input_one : (asn == lbm_pkg::ASN_TWO) ? s_strobe_input_two : 1'b0;
      // closed gate keeps the output off in every mode
      assign ir_en[gi]     = gate[gi] && md == lbm_pkg::MODE_IR;
      assign reg_flash[gi] = gate[gi] && md == lbm_pkg::MODE_FLASH && !sel_en;
      assign str_flash[gi] = gate[gi] && md == lbm_pkg::MODE_FLASH && sel_en && pin;
      // ir precharges while low, pulses while high
      assign want[gi] = (ir_en[gi] && sel_en && pin) || reg_flash[gi] || str_flash[gi]
                        || (gate[gi] && md == lbm_pkg::MODE_TORCH);
      assign rif.jump[gi]   = (md == lbm_pkg::MODE_IR);
      assign rif.target[gi] = (md == lbm_pkg::MODE_TORCH) ? torch_code[gi] : flash_code[gi];
    end
  endgenerate

  // activity summary
  assign led_req    = |want;
  assign ir_any     = |ir_en;
  assign active     = rail_en || led_req || ir_any;
  assign flash_live = |(reg_flash & r.src_on);
  assign timeout    = flash_live && r.cnt == 16'(FLASH_TO_CYC - 1);
  // rail asks for switching only when the target is above the input
  assign need_boost = (r.vsel == lbm_pkg::VOUT_TRACK) ? s_hr_low :
                      (r.vsel == lbm_pkg::VOUT_RAIL) ? s_rail_hi : 1'b0;
  // ramp runs only for driven sources, never for the bare rail
  assign rif.run = r.src_on;

  // next-state logic
  always_comb begin
    next_r = r;
    next_r.sync1 = {fault_event, rail_above_vin, headroom_low, vout_precharged,
                    vout_below_vin, strobe_input_two, strobe_input_one};
    next_r.sync2 = r.sync1;
    next_r.rdata = 8'h00;
    // converter sequence
    case (r.st)
      lbm_pkg::ST_STANDBY: begin
        if (active) begin
          next_r.st = lbm_pkg::ST_PRECHARGE;
        end
      end
      lbm_pkg::ST_PRECHARGE: begin
        if (!active) begin
          next_r.st = lbm_pkg::ST_STANDBY;
        end else if (s_pre || !s_below) begin
          next_r.st = lbm_pkg::ST_PASS;
        end
      end
      lbm_pkg::ST_PASS: begin
        if (!active) begin
          next_r.st = lbm_pkg::ST_STANDBY;
        end else if (need_boost) begin
          next_r.st = lbm_pkg::ST_BOOST;
        end
      end
      lbm_pkg::ST_BOOST: begin
        if (!active) begin
          next_r.st = lbm_pkg::ST_STANDBY;
        end else if (r.vsel != lbm_pkg::VOUT_TRACK && !need_boost) begin
          next_r.st = lbm_pkg::ST_PASS;
        end
      end
      default: begin
        next_r.st = lbm_pkg::ST_STANDBY;
      end
    endcase
    // output voltage target
    if (!rail_en) begin
      if (led_req) begin
        next_r.vsel = lbm_pkg::VOUT_TRACK;
      end else if (ir_any) begin
        next_r.vsel = lbm_pkg::VOUT_PRECHG;
      end else begin
        next_r.vsel = lbm_pkg::VOUT_OFF;
      end
    end else if (prio && led_req) begin
      next_r.vsel = lbm_pkg::VOUT_TRACK;
    end else if (s_rail_hi) begin
      // back to rail level once leds stop
      next_r.vsel = lbm_pkg::VOUT_RAIL;
    end else begin
      next_r.vsel = lbm_pkg::VOUT_PASS;
    end
    // sources only after precharge
    next_r.src_on = (r.st == lbm_pkg::ST_PASS || r.st == lbm_pkg::ST_BOOST) ? want : 4'h0;
    next_r.boost  = (next_r.st == lbm_pkg::ST_BOOST);
    next_r.prechg = (next_r.st == lbm_pkg::ST_PRECHARGE);
    // flash timer, idle in standby
    if (!flash_live || timeout) begin
      next_r.cnt = 16'h0000;
    end else begin
      next_r.cnt = r.cnt + 16'h0001;
    end
    if (!flash_live) begin
      next_r.mode_chg = 1'b0;
    end else if (reg_wr && reg_addr == lbm_pkg::MODE_ADDR) begin
      next_r.mode_chg = 1'b1;
    end
    if (timeout && !r.mode_chg) begin
      next_r.ctrl2[3:0] = 4'h0;
    end
    // a fault clears all gates, also under strobe control
    if (s_fault) begin
      next_r.ctrl2[3:0] = 4'h0;
    end
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        lbm_pkg::CTRL1_ADDR:  next_r.ctrl1 = reg_wdata;
        lbm_pkg::CTRL2_ADDR:  next_r.ctrl2 = reg_wdata;
        lbm_pkg::MODE_ADDR:   next_r.mode  = reg_wdata;
        lbm_pkg::ASSIGN_ADDR: next_r.asn   = reg_wdata;
        default:              next_r.ctrl1 = r.ctrl1;
      endcase
    end
    // register reads, unmapped reads zero
    if (reg_rd) begin
      case (reg_addr)
        lbm_pkg::CTRL1_ADDR:  next_r.rdata = r.ctrl1;
        lbm_pkg::CTRL2_ADDR:  next_r.rdata = r.ctrl2;
        lbm_pkg::MODE_ADDR:   next_r.rdata = r.mode;
        lbm_pkg::ASSIGN_ADDR: next_r.rdata = r.asn;
        lbm_pkg::STATUS_ADDR: next_r.rdata = {r.st, r.prechg, r.boost, r.src_on};
        default:              next_r.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r       <= '0;
      r.ctrl1 <= lbm_pkg::CTRL1_RST;
      r.ctrl2 <= lbm_pkg::CTRL2_RST;
      r.mode  <= lbm_pkg::MODE_RST;
      r.asn   <= lbm_pkg::ASSIGN_RST;
    end else begin
      r <= next_r;
    end
  end

  // current ramp generator
  lbm_ramp #(
    .STEP_CYC (lbm_pkg::RAMP_STEP_CYC)
  ) u_ramp (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .rif     (rif)
  );

  // outputs
  assign reg_rdata       = r.rdata;
  assign boost_switching = r.boost;
  assign precharge_on    = r.prechg;
  assign source_on       = r.src_on;
  assign led_code        = rif.level;
  assign vout_select     = r.vsel;
  assign rail_level      = r.ctrl1[lbm_pkg::LEVEL_LSB+1:lbm_pkg::LEVEL_LSB];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence leave_standby;
    r.st == lbm_pkg::ST_STANDBY ##1 r.st != lbm_pkg::ST_STANDBY;
  endsequence
  sequence strobe_flash_end;
    $fell(|str_flash) && !s_fault && !reg_wr && !timeout;
  endsequence

  a_gate_blocks_src: assert property ((r.src_on & ~$past(gate)) == 4'h0)
    else $error("source on with gate bit clear");
  a_precharge_no_src: assert property (r.prechg |-> r.src_on == 4'h0)
    else $error("source on during precharge");
  a_precharge_exit: assert property (r.st == lbm_pkg::ST_PRECHARGE && active && s_pre
    |=> r.st == lbm_pkg::ST_PASS ##1 r.st != lbm_pkg::ST_PRECHARGE)
    else $error("precharge did not end at threshold");
  a_standby_reset: assert property (r.st == lbm_pkg::ST_STANDBY [*3] |-> rif.level == '0 && r.cnt == 16'h0000)
    else $error("timers not reset in standby");
  a_start_in_pass: assert property (leave_standby |-> !r.boost ##1 !r.boost)
    else $error("boost switching right after standby");
  a_rail_regulate: assert property (rail_en && !(prio && led_req) && s_rail_hi
    |=> r.vsel == lbm_pkg::VOUT_RAIL)
    else $error("rail level not selected");
  a_rail_fallback: assert property (rail_en && !(prio && led_req) && !s_rail_hi
    |=> r.vsel == lbm_pkg::VOUT_PASS)
    else $error("rail not in pass below input");
  a_track_leds: assert property (rail_en && prio && led_req |=> r.vsel == lbm_pkg::VOUT_TRACK)
    else $error("led priority not tracking");
  a_idle_off: assert property (!rail_en && !led_req && !ir_any |=> r.vsel == lbm_pkg::VOUT_OFF)
    else $error("output not disabled when idle");
  a_timeout_clears: assert property (timeout && !r.mode_chg && !reg_wr && !s_fault |=> gate == 4'h0)
    else $error("gates kept after flash timeout");
  a_strobe_keeps: assert property (strobe_flash_end |=> gate == $past(gate))
    else $error("gates changed after strobe pulse");
endmodule
`default_nettype wire

// ---- lbm_host.sv ----
// host model: register bus master and strobe pin driver
`timescale 1ns/1ns
`default_nettype none
module lbm_host #(
  parameter int MIN_HOLD = 200
) (
  // clock
  input  wire logic       sys_clk,
  // register port
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  // strobe pins, bit 0 is strobe one
  output var  logic [1:0] strobe
);
  int held [2] = '{0, 0};
  // bus idle, pins low also in standby
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    strobe    = 2'b00;
  end
  // cycles each strobe has been high
  always @(posedge sys_clk) begin
    for (int i = 0; i < 2; i++) begin
      held[i] <= strobe[i] ? held[i] + 1 : 0;
    end
  end
  // one write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // raise a strobe pin
  task automatic raise(input int w);
    @(posedge sys_clk);
    strobe[w] <= 1'b1;
  endtask
  // lower a strobe pin, never before the minimum hold
  task automatic lower(input int w);
    @(posedge sys_clk);
    while (held[w] < MIN_HOLD) @(posedge sys_clk);
    strobe[w] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking testbench of the led boost mode control
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic               sys_clk = 1'b0;
  logic               rstn;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata;
  logic               reg_wr, reg_rd;
  logic [1:0]         strobe;
  logic               vout_below_vin, vout_precharged, headroom_low, rail_above_vin, fault_event;
  logic [3:0][7:0]    flash_code, torch_code, led_code;
  logic               boost_switching, precharge_on;
  logic [3:0]         source_on;
  lbm_pkg::lbm_vout_e vout_select;
  logic [1:0]         rail_level;
  int                 num_errors = 0;
  int                 tests_run = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  lbm_ctrl #(.FLASH_TO_CYC(64)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strobe_input_one(strobe[0]), .strobe_input_two(strobe[1]),
    .vout_below_vin(vout_below_vin), .vout_precharged(vout_precharged), .headroom_low(headroom_low),
    .rail_above_vin(rail_above_vin), .fault_event(fault_event), .flash_code(flash_code),
    .torch_code(torch_code), .boost_switching(boost_switching), .precharge_on(precharge_on),
    .source_on(source_on), .led_code(led_code), .vout_select(vout_select), .rail_level(rail_level));
  lbm_host i_host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strobe(strobe));
  // compare and count
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    check(n, {24'h0, d}, {24'h0, e});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // back to standby between scenarios
  task automatic idle();
    i_host.wr(8'h01, 8'h00);
    i_host.wr(8'h03, 8'h00);
    i_host.wr(8'h02, 8'h00);
    i_host.wr(8'h00, 8'h80);
    wait_n(6);
  endtask
  task automatic t_reset();
    check("rail_level", rail_level, 2'b10);
    check("vout off", vout_select, lbm_pkg::VOUT_OFF);
    rchk("ctrl1", 8'h00, lbm_pkg::CTRL1_RST);
    rchk("ctrl2", 8'h01, lbm_pkg::CTRL2_RST);
    rchk("mode", 8'h02, lbm_pkg::MODE_RST);
    rchk("assign", 8'h03, lbm_pkg::ASSIGN_RST);
    i_host.wr(8'h10, 8'h5a);
    rchk("unmapped", 8'h10, 8'h00);
    rchk("status", 8'h20, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_start();
    int         jumps;
    logic [7:0] prev;
    jumps = 0;
    @(posedge sys_clk) torch_code[0] <= 8'h02;
    i_host.wr(8'h02, 8'h02);
    i_host.wr(8'h01, 8'h01);
    wait_n(30);
    check("precharge on", precharge_on, 1'b1);
    check("sources held", source_on, 4'h0);
    @(posedge sys_clk) vout_precharged <= 1'b1;
    wait_n(6);
    check("precharge end", precharge_on, 1'b0);
    check("source 0 on", source_on, 4'h1);
    check("pass first", boost_switching, 1'b0);
    check("track", vout_select, lbm_pkg::VOUT_TRACK);
    prev = led_code[0];
    for (int i = 0; i < 100; i++) begin
      @(negedge sys_clk);
      if (led_code[0] > prev + 8'h01) jumps++;
      prev = led_code[0];
    end
    check("ramp steps", jumps, 0);
    check("ramp end", led_code[0], torch_code[0]);
    @(posedge sys_clk) headroom_low <= 1'b1;
    wait_n(6);
    check("boost", boost_switching, 1'b1);
    @(posedge sys_clk) headroom_low <= 1'b0;
    idle();
    check("standby codes", led_code, 32'h0);
    check("standby boost", boost_switching, 1'b0);
    check("standby vout", vout_select, lbm_pkg::VOUT_OFF);
    $display("test start done");
  endtask
  task automatic t_rail();
    for (int lv = 0; lv < 4; lv++) begin
      i_host.wr(8'h00, {lv[1:0], 6'h01});
      wait_n(12);
      check("level", rail_level, lv);
      check("rail", vout_select, lbm_pkg::VOUT_RAIL);
      check("rail boost", boost_switching, 1'b1);
      check("no source", {28'h0, source_on}, 32'h0);
      check("no ramp", led_code, 32'h0);
    end
    @(posedge sys_clk) rail_above_vin <= 1'b0;
    wait_n(8);
    check("rail pass", vout_select, lbm_pkg::VOUT_PASS);
    check("pass boost", boost_switching, 1'b0);
    @(posedge sys_clk) rail_above_vin <= 1'b1;
    idle();
    $display("test rail done");
  endtask
  task automatic t_prio();
    i_host.wr(8'h00, 8'h81);
    i_host.wr(8'h02, 8'h02);
    i_host.wr(8'h01, 8'h01);
    wait_n(12);
    check("rail first", vout_select, lbm_pkg::VOUT_RAIL);
    i_host.wr(8'h00, 8'h83);
    wait_n(4);
    check("led first", vout_select, lbm_pkg::VOUT_TRACK);
    i_host.wr(8'h01, 8'h00);
    wait_n(4);
    check("back to rail", vout_select, lbm_pkg::VOUT_RAIL);
    check("gated off", source_on, 4'h0);
    idle();
    $display("test priority done");
  endtask
  task automatic t_strobe();
    // one strobe per output, ir on strobe one, flash on strobe two
    @(posedge sys_clk) flash_code[1] <= 8'h55;
    i_host.wr(8'h02, 8'h34);
    i_host.wr(8'h03, 8'h24);
    i_host.wr(8'h01, 8'h36);
    wait_n(12);
    check("ir precharge", vout_select, lbm_pkg::VOUT_PRECHG);
    check("pins low", source_on, 4'h0);
    i_host.raise(0);
    wait_n(8);
    check("ir pulse", source_on, 4'h2);
    check("ir code", led_code[1], flash_code[1]);
    i_host.lower(0);
    wait_n(8);
    check("ir low", source_on, 4'h0);
    i_host.raise(1);
    wait_n(8);
    check("flash high", source_on, 4'h4);
    i_host.lower(1);
    wait_n(8);
    check("flash low", source_on, 4'h0);
    rchk("gates kept", 8'h01, 8'h36);
    @(posedge sys_clk) fault_event <= 1'b1;
    wait_n(6);
    @(posedge sys_clk) fault_event <= 1'b0;
    rchk("fault clear", 8'h01, 8'h30);
    // keep the device out of standby before touching a pin
    i_host.wr(8'h00, 8'h81);
    wait_n(6);
    i_host.raise(0);
    wait_n(8);
    check("gate off", source_on, 4'h0);
    i_host.lower(0);
    idle();
    $display("test strobe done");
  endtask
  task automatic t_flash();
    // precharge ends here on the output reaching the input
    @(posedge sys_clk) vout_precharged <= 1'b0;
    i_host.wr(8'h02, 8'h03);
    i_host.wr(8'h01, 8'h01);
    wait_n(12);
    check("below hold", precharge_on, 1'b1);
    check("below src", source_on, 4'h0);
    @(posedge sys_clk) vout_below_vin <= 1'b0;
    wait_n(6);
    check("reg flash", source_on, 4'h1);
    wait_n(90);
    rchk("auto clear", 8'h01, 8'h00);
    check("flash over", source_on, 4'h0);
    i_host.wr(8'h01, 8'h01);
    wait_n(20);
    i_host.wr(8'h02, 8'h03);
    wait_n(90);
    rchk("mode kept gates", 8'h01, 8'h01);
    idle();
    $display("test flash done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(50 * 40000);
    num_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim();
  end
  // main sequence, strobes only after leaving standby
  initial begin
    rstn            = 1'b0;
    vout_below_vin  = 1'b1;
    vout_precharged = 1'b0;
    headroom_low    = 1'b0;
    rail_above_vin  = 1'b1;
    fault_event     = 1'b0;
    flash_code      = {8'h40, 8'h30, 8'h20, 8'h10};
    torch_code      = {8'h04, 8'h03, 8'h03, 8'h03};
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    wait_n(2);
    t_reset();
    t_start();
    t_rail();
    t_prio();
    t_strobe();
    t_flash();
    end_sim();
  end
endmodule
`default_nettype wire
